// ==== ssx_defines.svh ====
// constants for the shift, subtract and exclusive-or datapath
`ifndef SSX_DEFINES_SVH
`define SSX_DEFINES_SVH

// widths
`define SSX_DW 16
`define SSX_PW 24
`define SSX_PGW 8
`define SSX_AW 40
`define SSX_LW 10
`define SSX_L5W 5
`define SSX_FW 12
`define SSX_CW 3
`define SSX_BYTE 8
`define SSX_NIB 4

// status flag positions
`define SSX_F_C 0
`define SSX_F_Z 1
`define SSX_F_OV 2
`define SSX_F_N 3
`define SSX_F_DC 4
`define SSX_F_OA 5
`define SSX_F_OB 6
`define SSX_F_SA 7
`define SSX_F_SB 8
`define SSX_F_SFA 9
`define SSX_F_OAB 10
`define SSX_F_SAB 11
`define SSX_FLAGS_RESET 12'h000

// accumulator guard region starts here
`define SSX_ACC_SIGN 31

// program word high byte position
`define SSX_PROG_HI 16

// cycle counts
`define SSX_CYC_ONE 3'h1
`define SSX_CYC_TBL_RD 3'h5
`define SSX_CYC_TBL_WT 3'h2
`define SSX_CYC_SFR 3'h1
`define SSX_CYC_NONE 3'h0

// stack word size in bytes
`define SSX_STACK_STEP 16'h0002

`endif

// ==== ssx_pkg.sv ====
// types for the shift, subtract and exclusive-or datapath
`default_nettype none
package ssx_pkg;
    typedef enum logic [4:0] {
        shift_left_op = 5'h00,
        shift_left_reg_op = 5'h01,
        shift_left_lit_op = 5'h02,
        acc_subtract_op = 5'h03,
        subtract_op = 5'h04,
        subtract_borrow_op = 5'h05,
        reverse_subtract_op = 5'h06,
        reverse_subtract_borrow_op = 5'h07,
        nibble_swap_op = 5'h08,
        byte_swap_op = 5'h09,
        table_read_high_op = 5'h0A,
        table_read_low_op = 5'h0B,
        table_write_high_op = 5'h0C,
        table_write_low_op = 5'h0D,
        frame_unlink_op = 5'h0E,
        xor_op = 5'h0F,
        zero_extend_op = 5'h10
    } ssx_op_t;
    typedef enum logic [1:0] {
        src_register = 2'h0,
        src_five_bit_literal = 2'h1,
        src_ten_bit_literal = 2'h2
    } ssx_src_t;
    typedef enum logic {
        st_idle = 1'h0,
        st_busy = 1'h1
    } ssx_state_t;
endpackage
`default_nettype wire

// ==== ssx_alu_if.sv ====
// operand and result bundle between sequencer and arithmetic unit
`include "ssx_defines.svh"
`default_nettype none
interface ssx_alu_if;
    import ssx_pkg::*;
    ssx_op_t op;
    logic [`SSX_DW-1:0] base;
    logic [`SSX_DW-1:0] opnd;
    logic acc_sel;
    logic [`SSX_AW-1:0] acc_a;
    logic [`SSX_AW-1:0] acc_b;
    logic [`SSX_FW-1:0] flags;
    logic [`SSX_DW-1:0] result;
    logic [`SSX_AW-1:0] acc_result;
    logic [`SSX_FW-1:0] next_flags;
    modport ctrl (output op, base, opnd, acc_sel, acc_a, acc_b, flags,
                  input result, acc_result, next_flags);
    modport alu (input op, base, opnd, acc_sel, acc_a, acc_b, flags,
                 output result, acc_result, next_flags);
endinterface
`default_nettype wire

// ==== ssx_alu.sv ====
// combinational result and flag logic
`include "ssx_defines.svh"
`default_nettype none
module ssx_alu
    import ssx_pkg::*;
(
    // operands in, results out
    ssx_alu_if.alu bus
);
    logic rev;
    logic brw;
    logic cin;
    logic nz_upd;
    logic [`SSX_DW-1:0] mx;
    logic [`SSX_DW-1:0] my;
    logic [`SSX_DW:0] diff;
    logic [`SSX_NIB:0] nib;
    logic sub_ov;
    logic [`SSX_DW-1:0] shl;
    logic [`SSX_AW-1:0] ax;
    logic [`SSX_AW-1:0] ay;
    logic [`SSX_AW:0] ad;
    logic [`SSX_AW-1-`SSX_ACC_SIGN:0] guard;
    logic acc_ovg;
    logic acc_ovf;
    logic [`SSX_DW-1:0] res;
    logic [`SSX_FW-1:0] nf;

    assign rev = bus.op == reverse_subtract_op || bus.op == reverse_subtract_borrow_op;
    assign brw = bus.op == subtract_borrow_op || bus.op == reverse_subtract_borrow_op;
    assign mx = rev ? bus.opnd : bus.base;
    assign my = rev ? bus.base : bus.opnd;
    // borrow forms take the inverted carry as an extra borrow
    assign cin = brw ? bus.flags[`SSX_F_C] : 1'b1;
    assign diff = {1'b0, mx} + {1'b0, ~my} + {{`SSX_DW{1'b0}}, cin};
    assign nib = {1'b0, mx[`SSX_NIB-1:0]} + {1'b0, ~my[`SSX_NIB-1:0]} + {{`SSX_NIB{1'b0}}, cin};
    assign sub_ov = (mx[`SSX_DW-1] != my[`SSX_DW-1]) && (diff[`SSX_DW-1] != mx[`SSX_DW-1]);
    // counts of sixteen or more clear the word
    assign shl = bus.base << bus.opnd[`SSX_L5W-1:0];
    assign ax = bus.acc_sel ? bus.acc_b : bus.acc_a;
    assign ay = bus.acc_sel ? bus.acc_a : bus.acc_b;
    assign ad = {ax[`SSX_AW-1], ax} - {ay[`SSX_AW-1], ay};
    assign guard = ad[`SSX_AW-1:`SSX_ACC_SIGN];
    assign acc_ovg = !((&guard) || !(|guard));
    assign acc_ovf = ad[`SSX_AW] != ad[`SSX_AW-1];
    assign nz_upd = bus.op inside {shift_left_op, shift_left_reg_op, shift_left_lit_op,
        subtract_op, subtract_borrow_op, reverse_subtract_op, reverse_subtract_borrow_op,
        xor_op, zero_extend_op};
    assign bus.result = res;
    assign bus.acc_result = ad[`SSX_AW-1:0];
    assign bus.next_flags = nf;

    always_comb begin
        res = bus.base;
        nf = bus.flags;
        case (bus.op)
            shift_left_op: begin
                res = {bus.base[`SSX_DW-2:0], 1'b0};
                nf[`SSX_F_C] = bus.base[`SSX_DW-1];
                nf[`SSX_F_OV] = bus.base[`SSX_DW-1] ^ bus.base[`SSX_DW-2];
            end
            shift_left_reg_op, shift_left_lit_op: res = shl;
            acc_subtract_op: begin
                // saturate flags are sticky, overflow flags follow each result
                if (bus.acc_sel) begin
                    nf[`SSX_F_OB] = acc_ovg;
                    nf[`SSX_F_SB] = bus.flags[`SSX_F_SB] | acc_ovf;
                end else begin
                    nf[`SSX_F_OA] = acc_ovg;
                    nf[`SSX_F_SA] = bus.flags[`SSX_F_SA] | acc_ovf;
                end
                nf[`SSX_F_OAB] = nf[`SSX_F_OA] | nf[`SSX_F_OB];
                nf[`SSX_F_SAB] = nf[`SSX_F_SA] | nf[`SSX_F_SB];
            end
            subtract_op, subtract_borrow_op, reverse_subtract_op,
            reverse_subtract_borrow_op: begin
                res = diff[`SSX_DW-1:0];
                nf[`SSX_F_C] = diff[`SSX_DW];
                nf[`SSX_F_DC] = nib[`SSX_NIB];
                nf[`SSX_F_OV] = sub_ov;
            end
            nibble_swap_op: res = {bus.base[`SSX_DW-1:`SSX_BYTE],
                bus.base[`SSX_NIB-1:0], bus.base[`SSX_BYTE-1:`SSX_NIB]};
            byte_swap_op: res = {bus.base[`SSX_BYTE-1:0],
                bus.base[`SSX_DW-1:`SSX_BYTE]};
            xor_op: res = bus.base ^ bus.opnd;
            zero_extend_op: begin
                res = {{`SSX_BYTE{1'b0}}, bus.opnd[`SSX_BYTE-1:0]};
                nf[`SSX_F_C] = 1'b1;
            end
            frame_unlink_op: begin
                res = bus.base - `SSX_STACK_STEP;
                nf[`SSX_F_SFA] = 1'b0;
            end
            default: ;
        endcase
        if (nz_upd) begin
            nf[`SSX_F_N] = res[`SSX_DW-1];
            nf[`SSX_F_Z] = res == '0;
        end
    end
endmodule
`default_nettype wire

// ==== ssx_tbl.sv ====
// program memory port for table reads and writes
`include "ssx_defines.svh"
`default_nettype none
module ssx_tbl
    import ssx_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // request from the sequencer
    input wire logic start,
    input wire ssx_op_t kind,
    input wire logic [`SSX_PW-1:0] addr,
    input wire logic [`SSX_DW-1:0] wdata,
    output logic [`SSX_DW-1:0] rd_data,
    // program memory
    output logic [`SSX_PW-1:0] prog_addr,
    output logic prog_rd,
    output logic prog_wr_high,
    output logic prog_wr_low,
    output logic [`SSX_PW-1:0] prog_wdata,
    input wire logic [`SSX_PW-1:0] prog_rdata
);
    logic rd_stage;
    logic hi_sel;
    logic is_rd;
    logic [`SSX_DW-1:0] next_rd_data;

    assign is_rd = kind == table_read_high_op || kind == table_read_low_op;
    assign next_rd_data = hi_sel
        ? {{`SSX_BYTE{1'b0}}, prog_rdata[`SSX_PW-1:`SSX_PROG_HI]}
        : prog_rdata[`SSX_DW-1:0];

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            prog_addr <= '0;
            prog_rd <= 1'b0;
            prog_wr_high <= 1'b0;
            prog_wr_low <= 1'b0;
            prog_wdata <= '0;
            rd_stage <= 1'b0;
            hi_sel <= 1'b0;
            rd_data <= '0;
        end else begin
            prog_rd <= start && is_rd;
            prog_wr_high <= start && kind == table_write_high_op;
            prog_wr_low <= start && kind == table_write_low_op;
            rd_stage <= prog_rd;
            if (start) begin
                prog_addr <= addr;
                hi_sel <= kind == table_read_high_op;
                // high write carries only the low byte, placed in the top lane
                prog_wdata <= kind == table_write_high_op
                    ? {wdata[`SSX_BYTE-1:0], {`SSX_DW{1'b0}}}
                    : {{`SSX_BYTE{1'b0}}, wdata};
            end
            // memory answers one cycle after the read strobe
            if (rd_stage) begin
                rd_data <= next_rd_data;
            end
        end
    end
endmodule
`default_nettype wire

// ==== ssx_datapath.sv ====
// shift, subtract, swap, exclusive-or and table access sequencer
`include "ssx_defines.svh"
`default_nettype none
// Function
// - single-bit left shift: one cycle, updates carry, negative, overflow, zero
// - left shift by register count: one cycle, updates negative and zero only
// - left shift by five-bit literal: one cycle, negative and zero only
// - accumulator subtract: one cycle, updates accumulator overflow, saturate, combined flags
// - register subtract base minus source: one cycle, five arithmetic flags
// - borrow forms also subtract inverted carry, five arithmetic flags
// - nibble swap of low byte: one cycle, no flag changes
// - byte swap: one cycle, no flag changes
// - high table read: program bits 23..16 into low byte, five cycles
// - low table read: program bits 15..0 into destination, five cycles
// - high table write: source low byte to program bits 23..16, two cycles
// - low table write: source word to program bits 15..0, two cycles
// - every exclusive-or form: one cycle, negative and zero only
// - ten-bit literal exclusive-or in place: one cycle, negative and zero
// - zero extend clears upper byte, one cycle, carry zero negative
// - frame unlink: one cycle, affects stack-frame-active flag
// - peripheral register read or read-modify-write costs one extra cycle
module ssx_datapath
    import ssx_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // instruction request
    input wire logic op_valid,
    output logic op_ready,
    input wire ssx_op_t op_code,
    input wire ssx_src_t op_src,
    input wire logic [`SSX_DW-1:0] base_val,
    input wire logic [`SSX_DW-1:0] src_val,
    input wire logic [`SSX_LW-1:0] lit_val,
    input wire logic sfr_extra,
    input wire logic acc_sel,
    input wire logic [`SSX_AW-1:0] acc_a,
    input wire logic [`SSX_AW-1:0] acc_b,
    input wire logic [`SSX_PGW-1:0] table_page,
    // results
    output logic done,
    output logic wr_en,
    output logic [`SSX_DW-1:0] wr_data,
    output logic fp_wr,
    output logic [`SSX_DW-1:0] fp_data,
    output logic acc_wr_a,
    output logic acc_wr_b,
    output logic [`SSX_AW-1:0] acc_data,
    output logic [`SSX_FW-1:0] status_flags,
    // program memory
    output logic [`SSX_PW-1:0] prog_addr,
    output logic prog_rd,
    output logic prog_wr_high,
    output logic prog_wr_low,
    output logic [`SSX_PW-1:0] prog_wdata,
    input wire logic [`SSX_PW-1:0] prog_rdata
);
    ssx_alu_if alu_bus ();
    ssx_state_t state;
    ssx_state_t next_state;
    ssx_op_t cur_op;
    ssx_op_t fin_op;
    logic [`SSX_CW-1:0] left;
    logic [`SSX_CW-1:0] next_left;
    logic [`SSX_CW-1:0] base_cyc;
    logic [`SSX_CW-1:0] total_cyc;
    logic [`SSX_DW-1:0] opnd;
    logic [`SSX_DW-1:0] rd_data;
    logic take;
    logic finish;
    logic is_rd;
    logic is_wt;
    logic is_tbl;
    logic fin_rd;
    logic fin_default_working_register;
    logic acc_sel_q;

    assign op_ready = state == st_idle;
    assign take = op_valid && op_ready;
    assign is_rd = op_code == table_read_high_op || op_code == table_read_low_op;
    assign is_wt = op_code == table_write_high_op || op_code == table_write_low_op;
    assign is_tbl = is_rd || is_wt;

    // literal operands are zero extended to a word
    assign opnd = op_src == src_five_bit_literal
        ? {{(`SSX_DW-`SSX_L5W){1'b0}}, lit_val[`SSX_L5W-1:0]}
        : op_src == src_ten_bit_literal
        ? {{(`SSX_DW-`SSX_LW){1'b0}}, lit_val}
        : src_val;

    // cycle budget per instruction
    assign base_cyc = is_rd ? `SSX_CYC_TBL_RD
        : is_wt ? `SSX_CYC_TBL_WT
        : `SSX_CYC_ONE;
    assign total_cyc = base_cyc + (sfr_extra ? `SSX_CYC_SFR : `SSX_CYC_NONE);

    // a one-cycle job finishes on the edge that takes it
    assign finish = (take && total_cyc == `SSX_CYC_ONE)
        || (state == st_busy && left == `SSX_CYC_ONE);
    assign fin_op = state == st_idle ? op_code : cur_op;
    assign fin_rd = fin_op == table_read_high_op || fin_op == table_read_low_op;
    assign fin_default_working_register = !(fin_op inside {acc_subtract_op, table_write_high_op,
        table_write_low_op});

    assign next_state = finish ? st_idle : take ? st_busy : state;
    assign next_left = take ? total_cyc - `SSX_CYC_ONE
        : state == st_busy ? left - `SSX_CYC_ONE : left;

    assign alu_bus.op = op_code;
    assign alu_bus.base = base_val;
    assign alu_bus.opnd = opnd;
    assign alu_bus.acc_sel = acc_sel;
    assign alu_bus.acc_a = acc_a;
    assign alu_bus.acc_b = acc_b;
    assign alu_bus.flags = status_flags;

    ssx_alu u_alu (
        .bus (alu_bus.alu)
    );

    // table ops take the address from the base word, data from the source
    ssx_tbl u_tbl (
        .clock (clock),
        .rst (rst),
        .start (take && is_tbl),
        .kind (op_code),
        .addr ({table_page, base_val}),
        .wdata (src_val),
        .rd_data (rd_data),
        .prog_addr (prog_addr),
        .prog_rd (prog_rd),
        .prog_wr_high (prog_wr_high),
        .prog_wr_low (prog_wr_low),
        .prog_wdata (prog_wdata),
        .prog_rdata (prog_rdata)
    );

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state <= st_idle;
            left <= `SSX_CYC_NONE;
            cur_op <= shift_left_op;
            acc_sel_q <= 1'b0;
        end else begin
            state <= next_state;
            left <= next_left;
            if (take) begin
                cur_op <= op_code;
                acc_sel_q <= acc_sel;
            end
        end
    end

    // flags move only on the taking edge; table ops leave them alone
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            status_flags <= `SSX_FLAGS_RESET;
        end else if (take && !is_tbl) begin
            status_flags <= alu_bus.next_flags;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            done <= 1'b0;
            wr_en <= 1'b0;
            fp_wr <= 1'b0;
            acc_wr_a <= 1'b0;
            acc_wr_b <= 1'b0;
            wr_data <= '0;
            fp_data <= '0;
            acc_data <= '0;
        end else begin
            done <= finish;
            wr_en <= finish && fin_default_working_register;
            fp_wr <= finish && fin_op == frame_unlink_op;
            acc_wr_a <= finish && fin_op == acc_subtract_op && !(take ? acc_sel : acc_sel_q);
            acc_wr_b <= finish && fin_op == acc_subtract_op && (take ? acc_sel : acc_sel_q);
            // table reads overwrite the word with memory data at the end
            if (finish && fin_rd) begin
                wr_data <= rd_data;
            end else if (take) begin
                wr_data <= alu_bus.result;
            end
            if (take) begin
                fp_data <= src_val;
                acc_data <= alu_bus.acc_result;
            end
        end
    end

    // checks
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);

    sequence s_next_done;
        done;
    endsequence
    sequence s_done_after2;
        !done ##1 done;
    endsequence
    sequence s_done_after5;
        !done [*4] ##1 done;
    endsequence

    AST_ONE_CYCLE_DONE: assert property (
        take && !is_tbl && !sfr_extra |=> s_next_done)
        else $error("single-cycle op did not finish in one cycle");
    AST_SFR_EXTRA: assert property (
        take && !is_tbl && sfr_extra |=> s_done_after2 ##0 wr_en == $past(fin_default_working_register))
        else $error("peripheral access did not add one cycle");
    AST_TBL_RD_FIVE: assert property (
        take && is_rd && !sfr_extra |=> s_done_after5 ##0 wr_en)
        else $error("table read did not take five cycles");
    AST_TBL_WT_TWO: assert property (
        take && is_wt && !sfr_extra |=> s_done_after2 ##0 !wr_en)
        else $error("table write did not take two cycles");
    AST_BUSY_BLOCKS: assert property (
        take && is_rd && !sfr_extra |=> !op_ready [*4] ##1 op_ready)
        else $error("ready returned at the wrong time after a table read");
    AST_TBL_HI_DATA: assert property (
        take && op_code == table_read_high_op && !sfr_extra
        |-> ##5 wr_data == {{`SSX_BYTE{1'b0}},
        $past(prog_rdata[`SSX_PW-1:`SSX_PROG_HI], 3)})
        else $error("high table read data misplaced");
    AST_TBL_WT_HI: assert property (
        take && op_code == table_write_high_op |=> prog_wr_high
        && prog_wdata[`SSX_PW-1:`SSX_PROG_HI] == $past(src_val[`SSX_BYTE-1:0]))
        else $error("high table write lane or data wrong");
    AST_TBL_FLAGS: assert property (
        take && is_tbl |=> $stable(status_flags))
        else $error("table access changed a flag");
    AST_SUB_FWD: assert property (
        take && op_code == subtract_op |=> wr_data == $past(base_val - opnd)
        && status_flags[`SSX_F_C] == ($past(base_val) >= $past(opnd)))
        else $error("forward subtract result or carry wrong");
    AST_SUB_BORROW: assert property (
        take && op_code == subtract_borrow_op |=> wr_data
        == $past(base_val - opnd - {{(`SSX_DW-1){1'b0}}, !status_flags[`SSX_F_C]}))
        else $error("borrow subtract result wrong");
    AST_SUB_REV: assert property (
        take && op_code == reverse_subtract_op |=> wr_data == $past(opnd - base_val))
        else $error("reverse subtract result wrong");
    AST_SWAP_KEEP: assert property (
        take && op_code inside {nibble_swap_op, byte_swap_op}
        |=> $stable(status_flags) && wr_en != $past(sfr_extra))
        else $error("swap changed a flag");
    AST_BYTE_SWAP: assert property (
        take && op_code == byte_swap_op |=> wr_data
        == {$past(base_val[`SSX_BYTE-1:0]), $past(base_val[`SSX_DW-1:`SSX_BYTE])})
        else $error("byte swap wrong");
    AST_XOR_NZ: assert property (
        take && op_code == xor_op |=> status_flags[`SSX_F_Z] == (wr_data == '0)
        && status_flags[`SSX_F_C] == $past(status_flags[`SSX_F_C])
        && status_flags[`SSX_F_OV] == $past(status_flags[`SSX_F_OV]))
        else $error("exclusive-or flag update wrong");
    AST_SHL_COUNT: assert property (
        take && op_code == shift_left_reg_op |=> wr_data
        == $past(base_val << opnd[`SSX_L5W-1:0])
        && status_flags[`SSX_F_C] == $past(status_flags[`SSX_F_C]))
        else $error("counted left shift wrong");
    AST_SHL_ONE: assert property (
        take && op_code == shift_left_op |=> status_flags[`SSX_F_C]
        == $past(base_val[`SSX_DW-1]) && status_flags[`SSX_F_N] == wr_data[`SSX_DW-1])
        else $error("single left shift flags wrong");
    AST_ZERO_EXT: assert property (
        take && op_code == zero_extend_op |=> wr_data[`SSX_DW-1:`SSX_BYTE] == '0
        && status_flags[`SSX_F_C] && !status_flags[`SSX_F_N])
        else $error("zero extend wrong");
    AST_UNLINK: assert property (
        take && op_code == frame_unlink_op && !sfr_extra
        |=> fp_wr && !status_flags[`SSX_F_SFA])
        else $error("unlink did not clear frame flag");
    AST_ACC_COMBINED: assert property (
        take && op_code == acc_subtract_op && !sfr_extra |=> (acc_wr_a || acc_wr_b)
        && status_flags[`SSX_F_OAB] == (status_flags[`SSX_F_OA] || status_flags[`SSX_F_OB]))
        else $error("accumulator combined flag wrong");
endmodule
`default_nettype wire

// ==== ssx_pmem.sv ====
// program memory model on the far side of the table port
`include "ssx_defines.svh"
`default_nettype none
module ssx_pmem (
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // program memory port
    input wire logic [`SSX_PW-1:0] prog_addr,
    input wire logic prog_rd,
    input wire logic prog_wr_high,
    input wire logic prog_wr_low,
    input wire logic [`SSX_PW-1:0] prog_wdata,
    output logic [`SSX_PW-1:0] prog_rdata
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [`SSX_PW-1:0] mem [16];
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            prog_rdata <= 24'h000000;
        end else begin
            if (prog_wr_high) mem[prog_addr[3:0]][23:16] <= prog_wdata[23:16];
            if (prog_wr_low) mem[prog_addr[3:0]][15:0] <= prog_wdata[15:0];
            // toggles outside the valid cycle so a late sample is seen
            prog_rdata <= prog_rd ? mem[prog_addr[3:0]] : ~prog_rdata;
        end
    end
endmodule
`default_nettype wire

// ==== ssx_datapath_tb.sv ====
// self-checking bench for the datapath sequencer
`include "ssx_defines.svh"
`default_nettype none
module ssx_datapath_tb import ssx_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    logic clock, rst, op_valid, sfr_extra, done, op_ready;
    logic prog_rd, prog_wr_high, prog_wr_low;
    ssx_op_t op_code;
    ssx_src_t op_src;
    logic [`SSX_DW-1:0] base_val, src_val, wr_data, b, s;
    logic [`SSX_LW-1:0] lit_val;
    logic [`SSX_FW-1:0] status_flags;
    logic [`SSX_PW-1:0] prog_addr, prog_wdata, prog_rdata;
    logic [`SSX_PGW-1:0] table_page;
    logic [2:0] ef;
    logic [18:0] m;
    int fail_count, n_compared, seed, i;
    ssx_op_t ops [10];
    ssx_datapath i_ssx_datapath (.clock(clock), .rst(rst), .op_valid(op_valid),
        .op_ready(op_ready), .op_code(op_code), .op_src(op_src), .base_val(base_val),
        .src_val(src_val), .lit_val(lit_val), .sfr_extra(sfr_extra), .acc_sel(1'h0),
        .acc_a(40'h0), .acc_b(40'h0), .table_page(table_page), .done(done), .wr_en(),
        .wr_data(wr_data), .fp_wr(), .fp_data(), .acc_wr_a(), .acc_wr_b(), .acc_data(),
        .status_flags(status_flags), .prog_addr(prog_addr), .prog_rd(prog_rd),
        .prog_wr_high(prog_wr_high), .prog_wr_low(prog_wr_low), .prog_wdata(prog_wdata),
        .prog_rdata(prog_rdata));
    ssx_pmem i_ssx_pmem (.clock(clock), .rst(rst), .prog_addr(prog_addr), .prog_rd(prog_rd),
        .prog_wr_high(prog_wr_high), .prog_wr_low(prog_wr_low), .prog_wdata(prog_wdata),
        .prog_rdata(prog_rdata));
    initial begin
        clock = 0;
        forever #25 clock = ~clock;
    end
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        n_compared++;
        if (e !== g) begin
            $display("wrong value %s expected %h seen %h", nm, e, g);
            fail_count++;
        end
    endtask
    task automatic results;
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // expected {c, z, n} and result; borrow forms reuse the carry left by earlier ops
    function automatic logic [18:0] model(ssx_op_t o, logic [15:0] x, logic [15:0] y,
                                          logic [9:0] l, logic [2:0] f);
        logic [16:0] d;
        logic [15:0] r;
        logic [2:0] g;
        logic ci;
        g = f;
        r = x;
        ci = (o == subtract_op || o == reverse_subtract_op) ? 1'b1 : f[2];
        d = (o == reverse_subtract_op || o == reverse_subtract_borrow_op) ?
            {1'b0, y} + {1'b0, ~x} + 17'(ci) : {1'b0, x} + {1'b0, ~y} + 17'(ci);
        case (o)
            subtract_op, subtract_borrow_op, reverse_subtract_op,
            reverse_subtract_borrow_op: {g[2], r} = d;
            xor_op: r = x ^ {6'h00, l};
            shift_left_op: {g[2], r} = {x, 1'b0};
            shift_left_lit_op: r = x << l[4:0];
            nibble_swap_op: r = {x[15:8], x[3:0], x[7:4]};
            byte_swap_op: r = {x[7:0], x[15:8]};
            default: {g[2], r} = {1'b1, 8'h00, y[7:0]};
        endcase
        if (o != nibble_swap_op && o != byte_swap_op) g[1:0] = {r == 16'h0000, r[15]};
        return {g, r};
    endfunction
    task automatic flg;
        chk("flags", 16'(ef), 16'({status_flags[`SSX_F_C], status_flags[`SSX_F_Z],
            status_flags[`SSX_F_N]}));
    endtask
    task automatic run(input ssx_op_t o, input logic [15:0] x, input logic [15:0] y,
                       input logic [9:0] l, input logic e);
        int n;
        @(negedge clock);
        op_valid = 1;
        op_code = o;
        op_src = (o == xor_op) ? src_ten_bit_literal :
                 (o == shift_left_lit_op) ? src_five_bit_literal : src_register;
        base_val = x;
        src_val = y;
        lit_val = l;
        sfr_extra = e;
        @(negedge clock);
        op_valid = 0;
        n = 1;
        while (done !== 1'b1 && n < 20) begin
            @(negedge clock);
            n++;
        end
        chk("cycles", 16'(((o == table_read_high_op || o == table_read_low_op) ? 5 :
            (o == table_write_high_op || o == table_write_low_op) ? 2 : 1) + e), 16'(n));
    endtask
    task automatic alu(input ssx_op_t o, input logic [15:0] x, input logic [15:0] y,
                       input logic [9:0] l, input logic e);
        run(o, x, y, l, e);
        m = model(o, x, y, l, ef);
        ef = m[18:16];
        chk("result", m[15:0], wr_data);
        flg();
    endtask
    initial begin
        rst = 1;
        {op_valid, sfr_extra, base_val, src_val, lit_val, table_page, ef} = '0;
        op_code = subtract_op;
        op_src = src_register;
        {seed, fail_count, n_compared} = {32'd55, 64'd0};
        ops = '{subtract_op, subtract_borrow_op, reverse_subtract_op, xor_op,
                reverse_subtract_borrow_op, shift_left_lit_op, nibble_swap_op,
                byte_swap_op, zero_extend_op, shift_left_op};
        repeat (3) @(negedge clock);
        rst = 0;
        chk("ready", 16'h0001, 16'(op_ready));
        flg();
        // corners: borrow out, shift by the top count, exclusive-or to zero
        alu(subtract_op, 16'h0000, 16'h0001, 10'h000, 1'b0);
        alu(subtract_borrow_op, 16'h8000, 16'h0000, 10'h000, 1'b1);
        alu(shift_left_lit_op, 16'hFFFF, 16'h0000, 10'h01F, 1'b0);
        alu(xor_op, 16'h03FF, 16'h0000, 10'h3FF, 1'b0);
        for (i = 0; i < 60; i++) begin
            alu(ops[i % 10], 16'($random(seed)), 16'($random(seed)), 10'($random(seed)),
                1'($random(seed)));
        end
        for (i = 0; i < 3; i++) begin
            b = 16'($random(seed));
            s = 16'($random(seed));
            table_page = 8'($random(seed));
            run(table_write_low_op, b, s, 10'h000, 1'b0);
            run(table_write_high_op, b, {s[7:0], s[15:8]}, 10'h000, 1'b0);
            run(table_read_low_op, b, 16'h0000, 10'h000, 1'b0);
            chk("read low", s, wr_data);
            run(table_read_high_op, b, 16'h0000, 10'h000, 1'b0);
            chk("read high", {8'h00, s[15:8]}, wr_data);
            flg();
        end
        results();
    end
    initial begin
        #250000;
        fail_count++;
        results();
    end
endmodule
`default_nettype wire
